/* inc/codec_ctrl_pkg.sv */
// Functional notes
// - Tone select 00 mutes, 01 second tone, 10 first tone, 11 both summed.
// - Waveform bit picks square wave at 0, sine wave at 1.
// - Whole 8-bit first tone word, msb at bit 7, sets first frequency.
// - Whole 8-bit second tone word sets second frequency.
// - Remote detect enable: 0 disables detection (reset), 1 enables it.
// - Remote output mode: 0 follows detector, 1 shows the detection latch.
// - Remote polarity: 0 drives output as is, 1 inverted.
// - Latch control 0 lets host clear latch; 1 lets detection set it.
// - Tone range 00 standard, 01 halved, 10 doubled; 11 forbidden to host.
// - Buzzer disabled holds output low; enabled gives pulse-width output.
// - Buzzer polarity: duty gives high width at 0, low width at 1.
// - Low six buzzer bits, msb at bit 5, give the duty number.
// - Two clock bits pick divider for 512k, 1.536M, 2.048M, 2.56M; 512k default.
// - Without master clock only tone and buzzer run.
// - Coding bit 5: 0 linear 14-bit (default), 1 companded 8-bit.
// - Companded: law bits 4 and 3 pick mu-law or A-law with/without inversion.
// - Linear: same law bits pick two's, one's complement or sign-magnitude.
// - Frame format bit 2: channels back to back, or two bits apart.
// - Seven-bit mode ignores received lsb and floats transmit in lsb slot.
// - Loopback bit 0 returns received slot byte on transmit, no coding.
// - Each access is two bytes: command with register, then contents.
// - PCM transmits msb first and takes first received bit as msb.
// - Tone route bit: 0 normal, 1 tone generator feeds transmit path.
package codec_ctrl_pkg;

   localparam int CLK_HZ           = 10_000_000;
   localparam int TONE_TICK_HZ     = 256_000;
   localparam int TONE_TICK_CYCLES = CLK_HZ / TONE_TICK_HZ;
   localparam int BUZZ_TICK_HZ     = 64_000;
   localparam int BUZZ_TICK_CYCLES = CLK_HZ / BUZZ_TICK_HZ;

   localparam logic [3:0] IDX_CODING_CLOCK = 4'h0;
   localparam logic [3:0] IDX_TONE_CONTROL = 4'h7;
   localparam logic [3:0] IDX_TONE_ONE     = 4'h8;
   localparam logic [3:0] IDX_TONE_TWO     = 4'h9;
   localparam logic [3:0] IDX_REMOTE       = 4'hA;
   localparam logic [3:0] IDX_BUZZER       = 4'hB;
   localparam int         CMD_READ_POS     = 7;

   localparam logic [7:0] TONE_CTRL_MASK = 8'hFF;
   localparam logic [7:0] TONE_AMPL      = 8'h64;
   localparam logic [1:0] RANGE_HALF     = 2'h1;
   localparam logic [1:0] RANGE_DOUBLE   = 2'h2;

   localparam logic [4:0] CH_ONE_START  = 5'h00;
   localparam logic [4:0] CH_TWO_BACK   = 5'h08;
   localparam logic [4:0] CH_TWO_GAP    = 5'h0A;
   localparam logic [4:0] SLOT_BITS     = 5'h08;

   typedef enum logic [2:0] {
      CTL_IDLE = 3'b001,
      CTL_CMD  = 3'b010,
      CTL_DATA = 3'b100
   } ctl_state_t;

   typedef struct packed {
      logic [3:0] tone_gain;
      logic       tone_one_select;
      logic       tone_two_select;
      logic       waveform_select;
      logic       tone_to_transmit_route;
   } tone_control_t;

   typedef struct packed {
      logic remote_enable;
      logic remote_output_latch_mode;
      logic remote_output_invert;
      logic remote_latch_control;
      logic preamp_gain_select;
      logic mic_bias_enable;
      logic tone_range_high_bit;
      logic tone_range_low_bit;
   } remote_config_t;

   typedef struct packed {
      logic       buzzer_enable;
      logic       buzzer_duty_polarity;
      logic [5:0] duty_word;
   } buzzer_control_t;

   typedef struct packed {
      logic [1:0] clock_divider;
      logic       coding_mode;
      logic       law_select_high;
      logic       law_select_low;
      logic       frame_format_select;
      logic       seven_bit_mode;
      logic       loopback_enable;
   } coding_clock_t;

   typedef struct packed {
      coding_clock_t   codingClock;
      tone_control_t   toneControl;
      logic [7:0]      toneOneFrequency;
      logic [7:0]      toneTwoFrequency;
      remote_config_t  remoteConfig;
      buzzer_control_t buzzerControl;
   } regs_t;

   typedef struct packed {
      logic ctrlClk;
      logic ctrlSelectN;
      logic ctrlDataIn;
      logic masterClockPresent;
      logic remoteDetect;
      logic pcmBitClk;
      logic pcmFrameSync;
      logic pcmRxData;
   } pins_t;

   localparam regs_t REGS_RESET = '0;
   localparam pins_t PINS_RESET = 8'h40;

endpackage

/* logic/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
   parameter int           W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         reset,
   // Raw pins and filtered levels
   input  wire logic [W-1:0] pinIn,
   output logic      [W-1:0] pinLevel
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } sync_t;

   sync_t q;
   sync_t n;

   always_comb begin
      n = q;
      n.s1 = pinIn;
      n.s2 = q.s1;
      n.s3 = q.s2;
      // A level moves only when two stages agree, so one odd sample is dropped
      n.lvl = (q.s2 & q.s3) | (q.lvl & (q.s2 | q.s3));
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         q <= {4{RST_VAL}};
      end else begin
         q <= n;
      end
   end

   assign pinLevel = q.lvl;

endmodule

/* logic/codec_control_register_set.sv */
`timescale 1ns/1ps
module codec_control_register_set
   import codec_ctrl_pkg::*;
#(
   parameter int TONE_TICK = TONE_TICK_CYCLES,
   parameter int BUZZ_TICK = BUZZ_TICK_CYCLES
) (
   // Clock and reset
   input  wire logic  clk,
   input  wire logic  reset,
   // Serial control channel pins
   input  wire logic  ctrlClk,
   input  wire logic  ctrlSelectN,
   input  wire logic  ctrlDataIn,
   output logic       ctrlDataOut,
   output logic       ctrlDataOutEn,
   // Clock status pin
   input  wire logic  masterClockPresent,
   // Remote detection
   input  wire logic  remoteDetectIn,
   output logic       remoteDetectOut,
   // PCM pins
   input  wire logic  pcmBitClk,
   input  wire logic  pcmFrameSync,
   input  wire logic  pcmReceiveInput,
   output logic       pcmTransmitOutput,
   output logic       pcmTransmitOutputEn,
   // Codec datapath side
   input  wire logic  secondChannel,
   input  wire logic [7:0] encodedByte,
   output logic [7:0] decodeByte,
   output logic       decodeValid,
   // Tone and buzzer
   output logic [8:0] toneSample,
   output logic       toneToTransmit,
   output logic       buzzerOut,
   // Register contents
   output regs_t      configRegs
);

   typedef struct packed {
      regs_t      regs;
      pins_t      prev;
      ctl_state_t ctl;
      logic [2:0] bitCnt;
      logic [7:0] shiftIn;
      logic       cmdRead;
      logic [3:0] cmdIdx;
      logic [7:0] shiftOut;
      logic       ctrlOut;
      logic       ctrlOutEn;
      logic [7:0] toneTick;
      logic [16:0] accOne;
      logic [16:0] accTwo;
      logic [8:0] toneSample;
      logic [7:0] buzzTick;
      logic [5:0] buzzPhase;
      logic       buzzerOut;
      logic       remoteLatch;
      logic       remoteOut;
      logic       frameSeen;
      logic [4:0] pcmBit;
      logic [7:0] rxShift;
      logic [7:0] rxByte;
      logic [7:0] txByte;
      logic [2:0] txK;
      logic       txOut;
      logic       txEn;
      logic [7:0] decodeByte;
      logic       decodeValid;
   } st_t;

   st_t   q;
   st_t   n;
   pins_t raw;
   pins_t pin;

   logic       ctlRise;
   logic       ctlFall;
   logic       selStart;
   logic       bitRise;
   logic       frameRise;
   logic       toneTickEnd;
   logic       buzzTickEnd;
   logic       det;
   logic       inSlot;
   logic [4:0] pcmIdx;
   logic [4:0] slotStart;
   logic [4:0] slotOff;
   logic [7:0] rxNext;
   logic [7:0] txFirst;
   logic [7:0] waveOne;
   logic [7:0] waveTwo;
   logic [8:0] toneMix;

   function automatic logic [7:0] readReg(input regs_t r, input logic [3:0] idx);
      case (idx)
         IDX_CODING_CLOCK: readReg = r.codingClock;
         IDX_TONE_CONTROL: readReg = r.toneControl & TONE_CTRL_MASK;
         IDX_TONE_ONE:     readReg = r.toneOneFrequency;
         IDX_TONE_TWO:     readReg = r.toneTwoFrequency;
         IDX_REMOTE:       readReg = r.remoteConfig;
         IDX_BUZZER:       readReg = r.buzzerControl;
         default:          readReg = 8'h00;
      endcase
   endfunction

   // Standard range steps by twice the word so halving keeps the word's lsb
   function automatic logic [16:0] toneStep(input logic [7:0] w, input logic [1:0] rng);
      if (rng == RANGE_HALF) begin
         toneStep = {9'h000, w};
      end else if (rng == RANGE_DOUBLE) begin
         toneStep = {7'h00, w, 2'h0};
      end else begin
         toneStep = {8'h00, w, 1'b0};
      end
   endfunction

   function automatic logic [7:0] quarterSine(input logic [2:0] i);
      case (i)
         3'h0:    quarterSine = 8'h0A;
         3'h1:    quarterSine = 8'h1D;
         3'h2:    quarterSine = 8'h2F;
         3'h3:    quarterSine = 8'h3F;
         3'h4:    quarterSine = 8'h4D;
         3'h5:    quarterSine = 8'h58;
         3'h6:    quarterSine = 8'h60;
         default: quarterSine = 8'h64;
      endcase
   endfunction

   function automatic logic [7:0] toneWave(input logic [16:0] acc, input logic sine);
      logic [7:0] mag;
      mag = sine ? quarterSine(acc[15] ? ~acc[14:12] : acc[14:12]) : TONE_AMPL;
      toneWave = acc[16] ? 8'(-mag) : mag;
   endfunction

   assign raw = {ctrlClk, ctrlSelectN, ctrlDataIn, masterClockPresent,
                 remoteDetectIn, pcmBitClk, pcmFrameSync, pcmReceiveInput};

   pin_sync #(
      .W       (8),
      .RST_VAL (PINS_RESET)
   ) pinSync (
      .clk      (clk),
      .reset    (reset),
      .pinIn    (raw),
      .pinLevel (pin)
   );

   assign ctlRise   = pin.ctrlClk & ~q.prev.ctrlClk;
   assign ctlFall   = ~pin.ctrlClk & q.prev.ctrlClk;
   assign selStart  = ~pin.ctrlSelectN & q.prev.ctrlSelectN;
   assign bitRise   = pin.pcmBitClk & ~q.prev.pcmBitClk;
   assign frameRise = pin.pcmFrameSync & ~q.prev.pcmFrameSync;

   assign toneTickEnd = q.toneTick == 8'(TONE_TICK - 1);
   assign buzzTickEnd = q.buzzTick == 8'(BUZZ_TICK - 1);

   assign waveOne = toneWave(q.accOne, q.regs.toneControl.waveform_select);
   assign waveTwo = toneWave(q.accTwo, q.regs.toneControl.waveform_select);
   assign toneMix = (q.regs.toneControl.tone_one_select ? {waveOne[7], waveOne} : 9'h000)
                  + (q.regs.toneControl.tone_two_select ? {waveTwo[7], waveTwo} : 9'h000);

   // Detection needs the master clock; tone and buzzer do not
   assign det = pin.remoteDetect & q.regs.remoteConfig.remote_enable
              & pin.masterClockPresent;

   assign pcmIdx    = q.frameSeen ? 5'h00 : (q.pcmBit == 5'h1F ? q.pcmBit : q.pcmBit + 5'h01);
   assign slotStart = !secondChannel ? CH_ONE_START
                    : (q.regs.codingClock.frame_format_select ? CH_TWO_GAP : CH_TWO_BACK);
   assign slotOff   = pcmIdx - slotStart;
   assign inSlot    = (pcmIdx >= slotStart) && (slotOff < SLOT_BITS);
   assign rxNext    = {q.rxShift[6:0], pin.pcmRxData};
   assign txFirst   = q.regs.codingClock.loopback_enable ? q.rxByte
                    : (q.regs.toneControl.tone_to_transmit_route ? toneMix[8:1]
                    : encodedByte);

   always_comb begin
      n = q;
      n.prev = pin;
      n.decodeValid = 1'b0;

      // Two-byte instruction: command byte then contents, msb first
      if (pin.ctrlSelectN) begin
         n.ctl = CTL_IDLE;
         n.ctrlOutEn = 1'b0;
      end else begin
         unique case (q.ctl)
            CTL_IDLE: begin
               if (selStart) begin
                  n.ctl = CTL_CMD;
                  n.bitCnt = 3'h0;
               end
            end
            CTL_CMD: begin
               if (ctlRise) begin
                  n.shiftIn = {q.shiftIn[6:0], pin.ctrlDataIn};
                  n.bitCnt = q.bitCnt + 3'h1;
                  if (q.bitCnt == 3'h7) begin
                     n.ctl = CTL_DATA;
                     n.cmdRead = n.shiftIn[CMD_READ_POS];
                     n.cmdIdx = n.shiftIn[3:0];
                     n.shiftOut = readReg(q.regs, n.shiftIn[3:0]);
                  end
               end
            end
            CTL_DATA: begin
               if (ctlFall && q.cmdRead) begin
                  n.ctrlOut = q.shiftOut[7];
                  n.ctrlOutEn = 1'b1;
                  n.shiftOut = {q.shiftOut[6:0], 1'b0};
               end
               if (ctlRise) begin
                  n.shiftIn = {q.shiftIn[6:0], pin.ctrlDataIn};
                  n.bitCnt = q.bitCnt + 3'h1;
                  if (q.bitCnt == 3'h7) begin
                     n.ctl = CTL_IDLE;
                     n.ctrlOutEn = 1'b0;
                     if (!q.cmdRead) begin
                        case (q.cmdIdx)
                           IDX_CODING_CLOCK: n.regs.codingClock = n.shiftIn;
                           IDX_TONE_CONTROL: n.regs.toneControl = n.shiftIn & TONE_CTRL_MASK;
                           IDX_TONE_ONE:     n.regs.toneOneFrequency = n.shiftIn;
                           IDX_TONE_TWO:     n.regs.toneTwoFrequency = n.shiftIn;
                           IDX_REMOTE:       n.regs.remoteConfig = n.shiftIn;
                           IDX_BUZZER:       n.regs.buzzerControl = n.shiftIn;
                           default:          n.regs = q.regs;
                        endcase
                     end
                  end
               end
            end
            default: begin
               n.ctl = CTL_IDLE;
            end
         endcase
      end

      // Tone generator: phase accumulators, top bit is the half period
      n.toneTick = toneTickEnd ? 8'h00 : q.toneTick + 8'h01;
      if (toneTickEnd) begin
         n.accOne = q.accOne + toneStep(q.regs.toneOneFrequency,
            {q.regs.remoteConfig.tone_range_high_bit,
             q.regs.remoteConfig.tone_range_low_bit});
         n.accTwo = q.accTwo + toneStep(q.regs.toneTwoFrequency,
            {q.regs.remoteConfig.tone_range_high_bit,
             q.regs.remoteConfig.tone_range_low_bit});
      end
      n.toneSample = toneMix;

      // Buzzer: 64-step period, duty word compared with phase
      n.buzzTick = buzzTickEnd ? 8'h00 : q.buzzTick + 8'h01;
      if (buzzTickEnd) begin
         n.buzzPhase = q.buzzPhase + 6'h01;
      end
      n.buzzerOut = q.regs.buzzerControl.buzzer_enable
         & ((q.buzzPhase < q.regs.buzzerControl.duty_word)
            ^ q.regs.buzzerControl.buzzer_duty_polarity);

      // Remote detection latch: clear level from host, set by detection
      if (!q.regs.remoteConfig.remote_latch_control || !q.regs.remoteConfig.remote_enable) begin
         n.remoteLatch = 1'b0;
      end else if (det) begin
         n.remoteLatch = 1'b1;
      end
      n.remoteOut = (q.regs.remoteConfig.remote_output_latch_mode ? n.remoteLatch : det)
                  ^ q.regs.remoteConfig.remote_output_invert;

      // PCM slot logic; data changes on the bit clock's rising edge
      if (!pin.masterClockPresent) begin
         n.txEn = 1'b0;
         n.frameSeen = 1'b0;
      end else begin
         if (bitRise) begin
            n.frameSeen = 1'b0;
            n.pcmBit = pcmIdx;
            n.txEn = 1'b0;
            if (inSlot) begin
               n.rxShift = rxNext;
               n.txK = slotOff[2:0];
               if (slotOff[2:0] == 3'h0) begin
                  n.txByte = txFirst;
               end
               n.txOut = n.txByte[3'h7 - slotOff[2:0]];
               n.txEn = !(q.regs.codingClock.seven_bit_mode && slotOff[2:0] == 3'h7);
               if (slotOff[2:0] == 3'h7) begin
                  n.rxByte = q.regs.codingClock.seven_bit_mode
                           ? {rxNext[7:1], 1'b0} : rxNext;
                  n.decodeByte = n.rxByte;
                  n.decodeValid = !q.regs.codingClock.loopback_enable;
               end
            end
         end
         if (frameRise) begin
            n.frameSeen = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         q <= '{regs: REGS_RESET, prev: PINS_RESET, ctl: CTL_IDLE, default: '0};
      end else begin
         q <= n;
      end
   end

   assign ctrlDataOut         = q.ctrlOut;
   assign ctrlDataOutEn       = q.ctrlOutEn;
   assign remoteDetectOut     = q.remoteOut;
   assign pcmTransmitOutput   = q.txOut;
   assign pcmTransmitOutputEn = q.txEn;
   assign decodeByte          = q.decodeByte;
   assign decodeValid         = q.decodeValid;
   assign toneSample          = q.toneSample;
   assign toneToTransmit      = q.regs.toneControl.tone_to_transmit_route;
   assign buzzerOut           = q.buzzerOut;
   assign configRegs          = q.regs;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   buzzer_off_a: assert property (!configRegs.buzzerControl.buzzer_enable |=> !buzzerOut)
      else $error("buzzer active while disabled");

   buzzer_zero_a: assert property (configRegs.buzzerControl.buzzer_enable
      && configRegs.buzzerControl.duty_word == 6'h00
      |=> buzzerOut == $past(configRegs.buzzerControl.buzzer_duty_polarity))
      else $error("zero duty buzzer level wrong for polarity");

   tone_mute_a: assert property (!configRegs.toneControl.tone_one_select
      && !configRegs.toneControl.tone_two_select |=> toneSample == 9'h000)
      else $error("tone not muted");

   remote_clear_a: assert property (configRegs.remoteConfig.remote_output_latch_mode
      && !configRegs.remoteConfig.remote_latch_control
      && !configRegs.remoteConfig.remote_output_invert |=> !remoteDetectOut)
      else $error("remote latch not cleared");

   remote_off_a: assert property (!configRegs.remoteConfig.remote_enable
      |=> remoteDetectOut == $past(configRegs.remoteConfig.remote_output_invert))
      else $error("remote output active while disabled");

   seven_bit_a: assert property (pcmTransmitOutputEn
      && $past(configRegs.codingClock.seven_bit_mode)
      |-> q.txK != 3'h7)
      else $error("transmit driven in lsb slot in seven bit mode");

   loop_decode_a: assert property (configRegs.codingClock.loopback_enable |=> !decodeValid)
      else $error("decode pulse during loopback");

   ctrl_drive_a: assert property (ctrlDataOutEn |-> q.ctl == CTL_DATA && q.cmdRead)
      else $error("control output driven outside read data byte");

endmodule

/* verif/control_host.sv */
`timescale 1ns/1ps
module control_host (
   // Clock
   input  wire logic clk,
   // Serial control channel
   output logic      ctrlClk,
   output logic      ctrlSelectN,
   output logic      ctrlDataIn,
   input  wire logic ctrlDataOut,
   input  wire logic ctrlDataOutEn
);
   // Half period of the control clock in system clocks; 5 is the fastest legal
   int halfClk = 6;

   initial begin
      ctrlClk     = 1'b0;
      ctrlSelectN = 1'b1;
      ctrlDataIn  = 1'b0;
   end

   // Command byte then contents byte, msb first; read bits taken on rising ctrlClk
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] wdata,
                       output logic [7:0] rdata);
      logic [15:0] word;
      word  = {cmd, wdata};
      rdata = 8'h00;
      @(negedge clk) ctrlSelectN = 1'b0;
      repeat (halfClk) @(negedge clk);
      for (int i = 15; i >= 0; i--) begin
         ctrlDataIn = word[i];
         repeat (halfClk) @(negedge clk);
         ctrlClk = 1'b1;
         if (i < 8 && ctrlDataOutEn === 1'b1) rdata[i] = ctrlDataOut;
         repeat (halfClk) @(negedge clk);
         ctrlClk = 1'b0;
      end
      // Released line must not keep showing the last bit
      ctrlDataIn  = ~ctrlDataIn;
      ctrlSelectN = 1'b1;
      repeat (8) @(negedge clk);
   endtask
endmodule

/* verif/codec_control_register_set_bench.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin \
   totalChecks++; \
   if ((got) !== (exp)) begin \
      nErrors++; \
      $display("Error at %0t ns: got %0h expected %0h", $time, got, exp); \
   end \
end
module codec_control_register_set_bench;
   import codec_ctrl_pkg::*;
   localparam int BT = 2;
   logic        clk, reset, ctrlClk, ctrlSelectN, ctrlDataIn, ctrlDataOut, ctrlDataOutEn;
   logic        masterClockPresent, remoteDetectIn, remoteDetectOut;
   logic        pcmBitClk, pcmFrameSync, pcmReceiveInput, secondChannel;
   logic        pcmTransmitOutput, pcmTransmitOutputEn, decodeValid, toneToTransmit, buzzerOut;
   logic [7:0]  encodedByte, decodeByte, rv, bz, tx, txOn, rx1, rx2;
   logic [8:0]  toneSample;
   logic [5:0]  d;
   regs_t       cfg;
   logic [15:0] expQ[$];
   logic [15:0] obsVal, expHead;
   event        obsEv;
   int          nErrors, totalChecks, nz, nDv;
   logic [31:0] rnd;
   logic [7:0]  w [7];
   logic [3:0]  idx [7] = '{IDX_CODING_CLOCK, IDX_TONE_CONTROL, IDX_TONE_ONE,
                            IDX_TONE_TWO, IDX_REMOTE, IDX_BUZZER, 4'h1};

   codec_control_register_set #(.TONE_TICK(2), .BUZZ_TICK(BT)) dut_u (
      .clk(clk), .reset(reset), .ctrlClk(ctrlClk), .ctrlSelectN(ctrlSelectN),
      .ctrlDataIn(ctrlDataIn), .ctrlDataOut(ctrlDataOut), .ctrlDataOutEn(ctrlDataOutEn),
      .masterClockPresent(masterClockPresent), .remoteDetectIn(remoteDetectIn),
      .remoteDetectOut(remoteDetectOut), .pcmBitClk(pcmBitClk), .pcmFrameSync(pcmFrameSync),
      .pcmReceiveInput(pcmReceiveInput), .pcmTransmitOutput(pcmTransmitOutput),
      .pcmTransmitOutputEn(pcmTransmitOutputEn), .secondChannel(secondChannel),
      .encodedByte(encodedByte), .decodeByte(decodeByte), .decodeValid(decodeValid),
      .toneSample(toneSample), .toneToTransmit(toneToTransmit), .buzzerOut(buzzerOut),
      .configRegs(cfg)
   );

   control_host host_u (
      .clk(clk), .ctrlClk(ctrlClk), .ctrlSelectN(ctrlSelectN), .ctrlDataIn(ctrlDataIn),
      .ctrlDataOut(ctrlDataOut), .ctrlDataOutEn(ctrlDataOutEn)
   );

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic note(input logic [15:0] e);
      expQ.push_back(e);
   endtask

   task automatic see(input logic [15:0] g);
      obsVal = g;
      -> obsEv;
      #1;
   endtask

   // One frame of 18 bit clocks; data moves while the clock is low, transmit read late when high
   task automatic pcmFrame(input logic [7:0] rx, input int s);
      for (int b = 0; b < 18; b++) begin
         pcmBitClk = 1'b0;
         pcmFrameSync = (b == 0);
         pcmReceiveInput = (b >= s && b < s + 8) ? rx[7 - b + s] : 1'b0;
         repeat (8) @(negedge clk);
         pcmBitClk = 1'b1;
         repeat (8) @(negedge clk);
         if (b >= s && b < s + 8) begin
            tx[7 - b + s] = pcmTransmitOutput;
            txOn[7 - b + s] = pcmTransmitOutputEn;
         end
      end
   endtask

   // Decode pulses stand one cycle, so they are counted on every falling edge
   always @(negedge clk) begin
      if (decodeValid === 1'b1) nDv++;
   end

   // Results are compared in arrival order against the oldest note
   always begin
      @(obsEv);
      expHead = expQ.pop_front();
      `CHK(obsVal, expHead)
   end

   task automatic stopTest();
      $display("Checks %0d, errors %0d", totalChecks, nErrors);
      if (nErrors == 0 && totalChecks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Whole run is near 1.5 ms; a hang is cut well after that
   initial begin
      #3_000_000;
      nErrors++;
      stopTest();
   end

   initial begin
      rnd = $urandom(47366);
      reset = 1'b1;
      masterClockPresent = 1'b1;
      remoteDetectIn = 1'b0;
      {pcmBitClk, pcmFrameSync, pcmReceiveInput, secondChannel} = 4'h0;
      encodedByte = 8'($urandom());
      w[6] = 8'h00;
      repeat (10) @(posedge clk);
      @(negedge clk) reset = 1'b0;
      repeat (4) @(negedge clk);
      for (int i = 0; i < 7; i++) begin
         host_u.xfer({1'b1, 3'h0, idx[i]}, 8'h00, rv);
         note(16'h0000);
         see({8'h00, rv});
      end
      // Clock word goes first, before anything else is programmed
      for (int i = 0; i < 6; i++) begin
         w[i] = 8'($urandom());
         if (i == 4 && w[i][1:0] == 2'h3) w[i][0] = 1'b0;
         host_u.halfClk = 5 + 4 * (i % 2);
         host_u.xfer({1'b0, 3'h0, idx[i]}, w[i], rv);
      end
      host_u.xfer({1'b0, 3'h0, 4'h1}, 8'hFF, rv);
      for (int i = 0; i < 7; i++) begin
         host_u.xfer({1'b1, 3'h0, idx[i]}, 8'h00, rv);
         note({8'h00, w[i]});
         see({8'h00, rv});
      end
      note(16'(w[1][0]));
      see(16'(toneToTransmit));
      note({w[2], w[3]});
      see({cfg.toneOneFrequency, cfg.toneTwoFrequency});
      note({w[0], w[5]});
      see({8'(cfg.codingClock), 8'(cfg.buzzerControl)});
      host_u.xfer({1'b0, 3'h0, IDX_TONE_ONE}, 8'hFF, rv);
      host_u.xfer({1'b0, 3'h0, IDX_TONE_TWO}, 8'hFF, rv);
      masterClockPresent = 1'b0;
      // Pass 4 plays the first tone alone as a square wave, so it sits at plus or minus 100
      for (int c = 0; c < 5; c++) begin
         host_u.xfer({1'b0, 3'h0, IDX_TONE_CONTROL},
                     {4'h0, 2'(c % 4 + c / 4 * 2), c < 4, 1'b0}, rv);
         nz = 0;
         repeat (10) @(negedge clk);
         repeat (600) @(negedge clk) begin
            if (c < 4 ? toneSample !== 9'h000
                      : (toneSample !== 9'h064 && toneSample !== 9'h19C)) nz++;
         end
         note(16'(c != 0 && c != 4));
         see(16'(nz != 0));
      end
      masterClockPresent = 1'b1;
      for (int k = 0; k < 3; k++) begin
         d = 6'($urandom_range(63, 1));
         bz = (k == 0) ? {2'b00, d} : {1'b1, k == 2, d};
         host_u.xfer({1'b0, 3'h0, IDX_BUZZER}, bz, rv);
         nz = 0;
         repeat (10) @(negedge clk);
         repeat (128 * BT) @(negedge clk) if (buzzerOut === 1'b1) nz++;
         note(16'((k == 0) ? 0 : (k == 1) ? 2 * BT * d : 2 * BT * (64 - d)));
         see(16'(nz));
      end
      host_u.xfer({1'b0, 3'h0, IDX_REMOTE}, 8'hA0, rv);
      remoteDetectIn = 1'b1;
      repeat (8) @(negedge clk);
      note(16'h0000);
      see(16'(remoteDetectOut));
      remoteDetectIn = 1'b0;
      repeat (8) @(negedge clk);
      note(16'h0001);
      see(16'(remoteDetectOut));
      host_u.xfer({1'b0, 3'h0, IDX_REMOTE}, 8'hD0, rv);
      remoteDetectIn = 1'b1;
      repeat (8) @(negedge clk);
      remoteDetectIn = 1'b0;
      repeat (8) @(negedge clk);
      note(16'h0001);
      see(16'(remoteDetectOut));
      host_u.xfer({1'b0, 3'h0, IDX_REMOTE}, 8'hC0, rv);
      note(16'h0000);
      see(16'(remoteDetectOut));
      // Plain slot, then loopback in seven-bit mode, then the second channel after the gap
      rx1 = 8'($urandom());
      rx2 = 8'($urandom());
      host_u.xfer({1'b0, 3'h0, IDX_CODING_CLOCK}, {w[0][7:6], 6'h00}, rv);
      pcmFrame(rx1, 0);
      note({rx1, encodedByte});
      see({decodeByte, tx});
      note({8'hFF, 8'h01});
      see({txOn, 8'(nDv)});
      host_u.xfer({1'b0, 3'h0, IDX_CODING_CLOCK}, {w[0][7:6], 6'h03}, rv);
      pcmFrame(rx2, 0);
      note({rx2 & 8'hFE, rx1 & 8'hFE});
      see({decodeByte, tx & 8'hFE});
      note({8'hFE, 8'h01});
      see({txOn, 8'(nDv)});
      secondChannel = 1'b1;
      host_u.xfer({1'b0, 3'h0, IDX_CODING_CLOCK}, {w[0][7:6], 6'h04}, rv);
      pcmFrame(rx2, 10);
      note({rx2, encodedByte});
      see({decodeByte, tx});
      note({8'hFF, 8'h02});
      see({txOn, 8'(nDv)});
      repeat (4) @(negedge clk);
      stopTest();
   end
endmodule
